/* File: verilog/iocs_io_control.sv */
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - sixteen main positions plus extender positions
// - switch register readable like any buffer
// - exactly one position enabled by a select below the position count
// - input strobe broadcast, selected word gated
// - input word stored into A or B
// - output strobe broadcast, selected buffer latches
// - output word read from A or B
// - test, set, clear selected control/flag
// - cards use control/flag to run transfers
// - requests honoured only after interrupt enable
// - request loads flag-specific address via the vector address bus
// - request forces the fetch phase
// - power-up halted with fetch indication on
// - instruction decoded only during fetch phase
module iocs_io_control import iocs_pkg::*; #(
    parameter int unsigned NUM_POS = MAIN_POS + EXT_POS
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    input wire logic run_i, // panel run button, async
    input wire logic [WORD_W-1:0] sw_reg_i, // panel switches, async
    input wire logic instr_valid_i,
    output logic instr_ready_o,
    input wire logic [WORD_W-1:0] instr_i,
    input wire logic [WORD_W-1:0] acc_a_i,
    input wire logic [WORD_W-1:0] acc_b_i,
    input wire logic [NUM_POS*WORD_W-1:0] card_data_i,
    input wire logic [NUM_POS-1:0] card_flag_i,
    output logic [NUM_POS-1:0] sel_en_o,
    output logic in_strobe_o,
    output logic out_strobe_o,
    output logic [WORD_W-1:0] out_bus_o,
    output logic set_flag_o,
    output logic clr_flag_o,
    output logic set_ctl_o,
    output logic clr_ctl_o,
    output logic skip_o,
    output logic read_a_o,
    output logic read_b_o,
    output logic store_a_o,
    output logic store_b_o,
    input wire logic store_ready_i,
    output logic [WORD_W-1:0] result_bus_o,
    output logic mar_load_o,
    output logic [WORD_W-1:0] mar_bus_o,
    output logic fetch_phase_signal_o,
    output logic halt_o,
    output logic ien_o
);
    // panel pins pass two flops before use
    // switches move by hand, so a word may settle a cycle late
    logic run_s1_r, run_s2_r;
    logic [WORD_W-1:0] sw_s1_r, sw_s2_r;
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            run_s1_r <= 1'b0;
            run_s2_r <= 1'b0;
            sw_s1_r <= RST_WORD;
            sw_s2_r <= RST_WORD;
        end else if (ce_i) begin
            run_s1_r <= run_i;
            run_s2_r <= run_s1_r;
            sw_s1_r <= sw_reg_i;
            sw_s2_r <= sw_s1_r;
        end
    end

    iocs_state_t st_r, st_nxt; // sequencer state
    logic [2:0] sub_r, sub_nxt; // latched sub-operation
    logic [SEL_W-1:0] sel_r, sel_nxt; // transfer register select bits
    logic accb_r, accb_nxt; // accumulator B chosen
    logic ien_r, ien_nxt; // interrupt system enabled
    logic run_d_r; // previous run level, edge detect
    logic [WORD_W-1:0] out_r, out_nxt; // word for output buffers
    logic [WORD_W-1:0] mar_r, mar_nxt; // vector address
    logic mload_r, mload_nxt; // vector load pulse
    logic [WORD_W-1:0] s_bus; // gated input word
    logic [NUM_POS-1:0] dec; // one-hot select decode
    logic irq_any; // any flag pending and honoured
    logic [SEL_W-1:0] irq_sel; // lowest flagged position wins
    logic is_io, take, run_pulse, buf_ready, buf_valid;
    logic [WORD_W:0] buf_out;

    // per-position decode and input gating
    genvar g;
    for (g = 0; g < NUM_POS; g++) begin : g_pos
        assign dec[g] = (sel_r == SEL_W'(g));
    end

    // or-gather the selected word; zeros when nothing matches
    always_comb begin
        s_bus = '0;
        for (int i = 0; i < NUM_POS; i++) begin
            if (dec[i]) begin
                s_bus = card_data_i[i*WORD_W +: WORD_W];
            end
        end
        if (sel_r == SEL_SWREG) begin
            s_bus = sw_s2_r;
        end
    end

    // fixed priority: lowest select code with a raised flag
    always_comb begin
        irq_sel = '0;
        for (int i = NUM_POS - 1; i >= 0; i--) begin
            if (card_flag_i[i]) begin
                irq_sel = SEL_W'(i);
            end
        end
    end

    // sequencer next state
    always_comb begin
        run_pulse = run_s2_r && !run_d_r;
        is_io = (instr_i[OPC_LSB +: OPC_W] == OPC_IO);
        irq_any = ien_r && (card_flag_i != '0);
        // an input can only start when the buffer has room; a low
        // enable must not look like an accepted word
        instr_ready_o = ce_i && (st_r == ST_FETCH) && !irq_any && buf_ready;
        take = instr_valid_i && instr_ready_o && is_io;
        st_nxt = st_r;
        sub_nxt = sub_r;
        sel_nxt = sel_r;
        accb_nxt = accb_r;
        ien_nxt = ien_r;
        out_nxt = out_r;
        mar_nxt = mar_r;
        mload_nxt = 1'b0;
        case (st_r)
            ST_HALT: begin
                if (run_pulse) begin
                    st_nxt = ST_FETCH;
                end
            end
            ST_FETCH: begin
                if (irq_any) begin
                    // vector through the vector address bus; return is software's job
                    mar_nxt = WORD_W'(irq_sel);
                    mload_nxt = 1'b1;
                    st_nxt = ST_FETCH;
                end else if (take) begin
                    sub_nxt = instr_i[SUB_LSB +: 3];
                    sel_nxt = instr_i[SEL_LSB +: SEL_W];
                    accb_nxt = instr_i[ACC_B_BIT];
                    out_nxt = instr_i[ACC_B_BIT] ? acc_b_i : acc_a_i;
                    st_nxt = ST_EXEC;
                end
            end
            ST_EXEC: begin
                st_nxt = (sub_r == SUB_HALT) ? ST_HALT : ST_FETCH;
                if (sel_r == SEL_INTSYS) begin
                    // select zero steers the interrupt system
                    if (sub_r == SUB_SETF) begin
                        ien_nxt = 1'b1;
                    end else if (sub_r == SUB_CLRF) begin
                        ien_nxt = 1'b0;
                    end
                end
            end
            default: st_nxt = ST_HALT;
        endcase
    end

    // sequencer registers; comes up halted
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            st_r <= ST_HALT;
            sub_r <= SUB_HALT;
            sel_r <= '0;
            accb_r <= 1'b0;
            ien_r <= RST_IEN;
            run_d_r <= 1'b0;
            out_r <= RST_WORD;
            mar_r <= RST_WORD;
            mload_r <= 1'b0;
        end else if (ce_i) begin
            st_r <= st_nxt;
            sub_r <= sub_nxt;
            sel_r <= sel_nxt;
            accb_r <= accb_nxt;
            ien_r <= ien_nxt;
            run_d_r <= run_s2_r;
            out_r <= out_nxt;
            mar_r <= mar_nxt;
            mload_r <= mload_nxt;
        end
    end

    // strobes to cards; the card's own bits run its peripheral
    always_comb begin
        logic ex;
        ex = (st_r == ST_EXEC) && ce_i;
        sel_en_o = ex ? dec : '0;
        in_strobe_o = ex && (sub_r == SUB_IN);
        out_strobe_o = ex && (sub_r == SUB_OUT);
        set_flag_o = ex && (sub_r == SUB_SETF);
        clr_flag_o = ex && (sub_r == SUB_CLRF);
        set_ctl_o = ex && (sub_r == SUB_SETC);
        clr_ctl_o = ex && (sub_r == SUB_CLRC);
        skip_o = ex && (sub_r == SUB_TSTF) &&
            ((card_flag_i & dec) != '0);
        read_a_o = take && !instr_i[ACC_B_BIT];
        read_b_o = take && instr_i[ACC_B_BIT];
        out_bus_o = out_r;
        fetch_phase_signal_o = (st_r != ST_EXEC);
        halt_o = (st_r == ST_HALT);
        ien_o = ien_r;
        mar_load_o = mload_r;
        mar_bus_o = mar_r;
    end

    // input word waits here until the accumulator accepts it
    iocs_buf2 #(
        .WIDTH(WORD_W + 1),
        .DEPTH(2)
    ) u_buf (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .ce_i(ce_i),
        .in_valid_i(in_strobe_o),
        .in_ready_o(buf_ready),
        .in_data_i({accb_r, s_bus}),
        .out_valid_o(buf_valid),
        .out_ready_i(store_ready_i),
        .out_data_o(buf_out)
    );

    // store enables pick the accumulator; held off while frozen,
    // since the head cannot pop then
    always_comb begin
        result_bus_o = buf_out[WORD_W-1:0];
        store_a_o = ce_i && buf_valid && !buf_out[WORD_W];
        store_b_o = ce_i && buf_valid && buf_out[WORD_W];
    end

    // checks
    a_one_hot_sel: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (st_r == ST_EXEC && sel_r < SEL_W'(NUM_POS) && ce_i)
        |-> $onehot(sel_en_o))
        else $error("select enable not one-hot");
    a_in_zero_idle: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (sel_r >= SEL_W'(NUM_POS) && sel_r != SEL_SWREG) |-> s_bus == '0)
        else $error("unmatched select gave nonzero word");
    a_in_stores: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (in_strobe_o && !store_a_o && !store_b_o)
        |=> (store_a_o || store_b_o || !ce_i))
        else $error("input word not presented for store");
    a_out_word: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (read_b_o && ce_i) |=> out_bus_o == $past(acc_b_i))
        else $error("output word not taken from B");
    a_out_strobe: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (take && ce_i && instr_i[SUB_LSB +: 3] == SUB_OUT)
        |=> out_strobe_o || !ce_i)
        else $error("output strobe missing");
    a_no_irq_off: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        !ien_r |=> !mar_load_o)
        else $error("vector without interrupt enable");
    a_irq_vector: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (st_r == ST_FETCH && irq_any && ce_i)
        |=> mar_load_o && fetch_phase_signal_o)
        else $error("flag request not vectored");
    a_decode_fetch: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        instr_ready_o |-> fetch_phase_signal_o && !halt_o)
        else $error("instruction taken outside fetch");
    a_halt_fetch: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        halt_o |-> fetch_phase_signal_o)
        else $error("halt without fetch indication");
endmodule
`default_nettype wire

/* File: verilog/iocs_pkg.sv */
package iocs_pkg;
    // word and select widths
    localparam int unsigned WORD_W = 16;
    localparam int unsigned SEL_W = 6;
    localparam int unsigned OPC_W = 6;
    // main frame positions plus the larger extender option
    localparam int unsigned MAIN_POS = 16;
    localparam int unsigned EXT_POS = 32;
    // instruction field positions
    localparam int unsigned OPC_LSB = 10;
    localparam int unsigned ACC_B_BIT = 9;
    localparam int unsigned SUB_LSB = 6;
    localparam int unsigned SEL_LSB = 0;
    // top six bits that mark an input/output instruction
    localparam logic [5:0] OPC_IO = 6'h38;
    // sub-operation codes, bits 8..6
    localparam logic [2:0] SUB_HALT = 3'h0;
    localparam logic [2:0] SUB_TSTF = 3'h1;
    localparam logic [2:0] SUB_SETF = 3'h2;
    localparam logic [2:0] SUB_CLRF = 3'h3;
    localparam logic [2:0] SUB_SETC = 3'h4;
    localparam logic [2:0] SUB_CLRC = 3'h5;
    localparam logic [2:0] SUB_IN = 3'h6;
    localparam logic [2:0] SUB_OUT = 3'h7;
    // select code zero is the interrupt system itself
    localparam logic [5:0] SEL_INTSYS = 6'h00;
    // front-panel switch register position
    localparam logic [5:0] SEL_SWREG = 6'h01;
    // reset values
    localparam logic RST_IEN = 1'b0;
    localparam logic [15:0] RST_WORD = 16'h0000;
    // control states, gray along halt -> fetch -> exec
    typedef enum logic [1:0] {
        ST_HALT = 2'b00,
        ST_FETCH = 2'b01,
        ST_EXEC = 2'b11
    } iocs_state_t;
endpackage

/* File: verilog/iocs_buf2.sv */
`timescale 1ns/100ps
`default_nettype none
// two-entry buffer: a stall downstream loses nothing
module iocs_buf2 #(
    parameter int unsigned WIDTH = 17,
    parameter int unsigned DEPTH = 2
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    logic [WIDTH-1:0] mem_r [DEPTH]; // storage array
    logic [PW-1:0] wp_r, wp_nxt; // write pointer
    logic [PW-1:0] rp_r, rp_nxt; // read pointer
    logic [PW:0] cnt_r, cnt_nxt; // fill level
    logic push, pop;

    // handshakes and pointer updates
    always_comb begin
        in_ready_o = (cnt_r != (PW+1)'(DEPTH));
        out_valid_o = (cnt_r != '0);
        push = in_valid_i && in_ready_o;
        pop = out_valid_o && out_ready_i;
        wp_nxt = wp_r;
        rp_nxt = rp_r;
        if (push) begin
            wp_nxt = (wp_r == PW'(DEPTH - 1)) ? '0 : wp_r + PW'(1);
        end
        if (pop) begin
            rp_nxt = (rp_r == PW'(DEPTH - 1)) ? '0 : rp_r + PW'(1);
        end
        cnt_nxt = cnt_r + (PW+1)'(push) - (PW+1)'(pop);
        out_data_o = mem_r[rp_r];
    end

    // registers; frozen while the enable is low
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else if (ce_i) begin
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // storage has no reset; only valid entries are read
    always_ff @(posedge clk_i) begin
        if (ce_i && push) begin
            mem_r[wp_r] <= in_data_i;
        end
    end
endmodule
`default_nettype wire

/* File: testbench/iocs_card_model.sv */
`timescale 1ns/100ps
`default_nettype none
// peripheral cards behind the positions: buffers, control and flag bits
module iocs_card_model import iocs_pkg::*; #(
    parameter int unsigned NUM_POS = MAIN_POS + EXT_POS
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic [NUM_POS-1:0] sel_en_i, // one-hot position enable
    input wire logic out_strobe_i,
    input wire logic [WORD_W-1:0] out_bus_i,
    input wire logic set_flag_i,
    input wire logic clr_flag_i,
    input wire logic set_ctl_i,
    input wire logic clr_ctl_i,
    input wire logic [NUM_POS-1:0] raise_i, // bench: device wants service
    input wire logic [NUM_POS-1:0] drop_i, // bench: service routine done
    output logic [NUM_POS*WORD_W-1:0] card_data_o,
    output logic [NUM_POS-1:0] card_flag_o,
    output logic [NUM_POS-1:0] ctl_o,
    output logic [NUM_POS*WORD_W-1:0] latched_o
);
    // 0 is the interrupt system, 1 the switch register: no card obeys
    localparam int unsigned FIRST_CARD = 2;

    // cards react only to strobes while their position is enabled
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            card_flag_o <= '0;
            ctl_o <= '0;
            latched_o <= '0;
        end else begin
            for (int p = FIRST_CARD; p < NUM_POS; p++) begin
                if (sel_en_i[p] && out_strobe_i) begin
                    latched_o[p*WORD_W +: WORD_W] <= out_bus_i;
                end
                // a raised flag is the service request itself
                if (raise_i[p] || (sel_en_i[p] && set_flag_i)) begin
                    card_flag_o[p] <= 1'b1;
                end else if (drop_i[p] || (sel_en_i[p] && clr_flag_i)) begin
                    card_flag_o[p] <= 1'b0;
                end
                if (sel_en_i[p] && set_ctl_i) begin
                    ctl_o[p] <= 1'b1;
                end else if (sel_en_i[p] && clr_ctl_i) begin
                    ctl_o[p] <= 1'b0;
                end
            end
        end
    end

    // input buffers hold a pattern naming their position
    always_comb begin
        for (int p = 0; p < NUM_POS; p++) begin
            card_data_o[p*WORD_W +: WORD_W] = 16'h5a00 | 16'(p);
        end
    end
endmodule
`default_nettype wire

/* File: testbench/tb_io_control_and_service_request.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_io_control_and_service_request import iocs_pkg::*;;
    localparam int unsigned NUM = MAIN_POS + EXT_POS;
    localparam time DLY = 1;
    logic clk_i = 1'b0, sys_rst_i = 1'b1, run_i = 1'b0;
    logic instr_valid_i = 1'b0, store_ready_i = 1'b0;
    logic ce_i = 1'b1; // low freezes the block
    logic [15:0] instr_i = '0, acc_a_i = 16'h1234, acc_b_i = 16'hfedc;
    logic [15:0] sw_reg_i = 16'hc3a5; // distinct from any card pattern
    logic [NUM*16-1:0] card_data, latched;
    logic [NUM-1:0] card_flag, ctl, sel_en_o, raise = '0, drop = '0;
    logic in_strobe_o, out_strobe_o, set_flag_o, clr_flag_o, set_ctl_o;
    logic clr_ctl_o, skip_o, read_a_o, read_b_o, store_a_o, store_b_o;
    logic mar_load_o, fetch_phase_signal_o, halt_o, ien_o, instr_ready_o;
    logic [15:0] out_bus_o, result_bus_o, mar_bus_o;
    logic [17:0] head; // store enables and word at the buffer head
    assign head = {store_a_o, store_b_o, result_bus_o};
    int error_cnt = 0, total_checks = 0;

    initial begin
        forever #4 clk_i = ~clk_i;
    end

    iocs_io_control #(.NUM_POS(NUM)) dut (.clk_i(clk_i),
        .sys_rst_i(sys_rst_i), .ce_i(ce_i), .run_i(run_i),
        .sw_reg_i(sw_reg_i), .instr_valid_i(instr_valid_i),
        .instr_ready_o(instr_ready_o), .instr_i(instr_i),
        .acc_a_i(acc_a_i), .acc_b_i(acc_b_i), .card_data_i(card_data),
        .card_flag_i(card_flag), .sel_en_o(sel_en_o),
        .in_strobe_o(in_strobe_o), .out_strobe_o(out_strobe_o),
        .out_bus_o(out_bus_o), .set_flag_o(set_flag_o),
        .clr_flag_o(clr_flag_o), .set_ctl_o(set_ctl_o),
        .clr_ctl_o(clr_ctl_o), .skip_o(skip_o), .read_a_o(read_a_o),
        .read_b_o(read_b_o), .store_a_o(store_a_o), .store_b_o(store_b_o),
        .store_ready_i(store_ready_i), .result_bus_o(result_bus_o),
        .mar_load_o(mar_load_o), .mar_bus_o(mar_bus_o),
        .fetch_phase_signal_o(fetch_phase_signal_o), .halt_o(halt_o),
        .ien_o(ien_o));

    iocs_card_model #(.NUM_POS(NUM)) cards (.clk_i(clk_i),
        .sys_rst_i(sys_rst_i), .sel_en_i(sel_en_o),
        .out_strobe_i(out_strobe_o), .out_bus_i(out_bus_o),
        .set_flag_i(set_flag_o), .clr_flag_i(clr_flag_o),
        .set_ctl_i(set_ctl_o), .clr_ctl_i(clr_ctl_o), .raise_i(raise),
        .drop_i(drop), .card_data_o(card_data), .card_flag_o(card_flag),
        .ctl_o(ctl), .latched_o(latched));

    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: bit %b expected %b", $time, got, exp);
        end
    endtask

    task automatic chk_word(input logic [47:0] got, input logic [47:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: word %h expected %h", $time, got, exp);
        end
    endtask

    function automatic logic [15:0] enc(logic [2:0] sub, logic b,
                                        logic [5:0] s);
        return {OPC_IO, b, sub, s};
    endfunction

    // bounded wait at falling edges until the block is ready to take a word
    task automatic wait_ready();
        int n;
        n = 0;
        @(negedge clk_i);
        while (instr_ready_o !== 1'b1) begin
            n++;
            if (n == 60) begin
                $display("mismatch at %0t: ready never came", $time);
                error_cnt++;
                conclude();
            end
            @(negedge clk_i);
        end
    endtask

    // offer one word, then judge the execute cycle that follows
    task automatic issue(input logic [15:0] w, input logic skp);
        logic io;
        logic [2:0] sub;
        logic [47:0] en;
        io = (w[15:10] == OPC_IO);
        sub = w[8:6];
        en = (io && w[5:0] < NUM) ? 48'h1 << w[5:0] : '0;
        @(posedge clk_i);
        #DLY instr_i = w;
        instr_valid_i = 1'b1;
        wait_ready();
        // every accepted I/O word reads its accumulator at accept
        chk_bit(read_a_o, io && !w[9]);
        chk_bit(read_b_o, io && w[9]);
        @(posedge clk_i);
        #DLY instr_valid_i = 1'b0;
        @(negedge clk_i);
        if (io) chk_bit(fetch_phase_signal_o, 1'b0);
        chk_word(sel_en_o, en);
        chk_bit(in_strobe_o, io && sub == SUB_IN);
        chk_bit(out_strobe_o, io && sub == SUB_OUT);
        chk_bit(set_flag_o, io && sub == SUB_SETF);
        chk_bit(clr_flag_o, io && sub == SUB_CLRF);
        chk_bit(set_ctl_o, io && sub == SUB_SETC);
        chk_bit(clr_ctl_o, io && sub == SUB_CLRC);
        chk_bit(skip_o, io && sub == SUB_TSTF && skp);
    endtask

    task automatic t_power_up();
        chk_bit(halt_o, 1'b1);
        chk_bit(fetch_phase_signal_o, 1'b1);
        chk_bit(ien_o, 1'b0);
        chk_bit(instr_ready_o, 1'b0);
        #DLY run_i = 1'b1;
        wait_ready();
        chk_bit(halt_o, 1'b0);
        $display("test power_up done");
    endtask

    // control and flag bits of card 5; the flag test skips only when set
    task automatic t_ctl_flag();
        issue(enc(SUB_SETC, 1'b0, 6'h05), 1'b0);
        @(posedge clk_i);
        #DLY chk_bit(ctl[5], 1'b1);
        issue(enc(SUB_CLRC, 1'b0, 6'h05), 1'b0);
        issue(enc(SUB_SETF, 1'b0, 6'h05), 1'b0);
        issue(enc(SUB_TSTF, 1'b0, 6'h05), 1'b1);
        issue(enc(SUB_CLRF, 1'b0, 6'h05), 1'b0);
        issue(enc(SUB_TSTF, 1'b0, 6'h05), 1'b0);
        chk_word(ctl | card_flag, '0);
        $display("test ctl_flag done");
    endtask

    // a low enable holds the execute cycle and masks its strobe
    task automatic t_freeze();
        @(posedge clk_i);
        #DLY instr_i = enc(SUB_SETC, 1'b0, 6'h06);
        instr_valid_i = 1'b1;
        wait_ready();
        @(posedge clk_i);
        #DLY instr_valid_i = 1'b0;
        ce_i = 1'b0;
        @(negedge clk_i);
        chk_bit(set_ctl_o, 1'b0);
        chk_word(sel_en_o, '0);
        @(posedge clk_i);
        #DLY chk_bit(ctl[6], 1'b0);
        chk_bit(fetch_phase_signal_o, 1'b0);
        ce_i = 1'b1;
        @(negedge clk_i);
        chk_bit(set_ctl_o, 1'b1);
        @(posedge clk_i);
        #DLY chk_bit(ctl[6], 1'b1);
        issue(enc(SUB_CLRC, 1'b0, 6'h06), 1'b0);
        $display("test freeze done");
    endtask

    // two words wait while the accumulators stall, then leave in order
    task automatic t_input();
        issue(enc(SUB_IN, 1'b0, 6'h07), 1'b0);
        @(negedge clk_i);
        chk_bit(store_a_o, 1'b1);
        chk_word(result_bus_o, 16'h5a07);
        issue(enc(SUB_IN, 1'b1, SEL_SWREG), 1'b0);
        @(negedge clk_i);
        chk_bit(instr_ready_o, 1'b0);
        @(posedge clk_i);
        #DLY store_ready_i = 1'b1;
        @(negedge clk_i);
        chk_word(head, {2'b10, 16'h5a07});
        @(negedge clk_i);
        chk_word(head, {2'b01, sw_reg_i});
        @(posedge clk_i);
        #DLY store_ready_i = 1'b0;
        issue(enc(SUB_IN, 1'b0, 6'h3f), 1'b0);
        @(negedge clk_i);
        chk_word({store_a_o, result_bus_o}, {1'b1, 16'h0000});
        @(posedge clk_i);
        #DLY store_ready_i = 1'b1;
        @(posedge clk_i);
        #DLY store_ready_i = 1'b0;
        chk_bit(store_a_o, 1'b0);
        $display("test input done");
    endtask

    // main frame and extender positions; only the chosen one latches
    task automatic t_output();
        issue(enc(SUB_OUT, 1'b0, 6'h09), 1'b0);
        chk_word(out_bus_o, acc_a_i);
        issue(enc(SUB_OUT, 1'b1, 6'h28), 1'b0);
        @(posedge clk_i);
        #DLY chk_word(latched[9*16 +: 16], acc_a_i);
        chk_word(latched[40*16 +: 16], acc_b_i);
        chk_word(latched[10*16 +: 16], '0);
        $display("test output done");
    endtask

    task automatic wait_vector(input logic [15:0] pos);
        int n;
        n = 0;
        while (n < 12 && !(mar_load_o === 1'b1 && mar_bus_o === pos)) begin
            @(negedge clk_i);
            n++;
        end
        chk_bit(n < 12, 1'b1);
        chk_bit(fetch_phase_signal_o, 1'b1);
    endtask

    // requests wait for enable; lowest flagged position wins
    task automatic t_service();
        int hits;
        hits = 0;
        @(posedge clk_i);
        #DLY raise = (48'h1 << 12) | (48'h1 << 30);
        @(posedge clk_i);
        #DLY raise = '0;
        repeat (8) @(negedge clk_i) hits += mar_load_o;
        chk_word(48'(hits), '0);
        issue(enc(SUB_SETF, 1'b0, SEL_INTSYS), 1'b0);
        // the enable lands at the end of the execute cycle
        @(negedge clk_i);
        chk_bit(ien_o, 1'b1);
        wait_vector(16'd12);
        @(posedge clk_i);
        #DLY drop = 48'h1 << 12;
        @(posedge clk_i);
        #DLY drop = '0;
        wait_vector(16'd30);
        @(posedge clk_i);
        #DLY drop = 48'h1 << 30;
        @(posedge clk_i);
        #DLY drop = '0;
        issue(enc(SUB_CLRF, 1'b0, SEL_INTSYS), 1'b0);
        @(negedge clk_i);
        chk_bit(ien_o, 1'b0);
        $display("test service done");
    endtask

    task automatic t_halt();
        issue(16'h3000, 1'b0);
        issue(enc(SUB_HALT, 1'b0, 6'h00), 1'b0);
        @(negedge clk_i);
        chk_bit(halt_o, 1'b1);
        chk_bit(fetch_phase_signal_o, 1'b1);
        $display("test halt done");
    endtask

    initial begin
        repeat (10) @(posedge clk_i);
        #DLY sys_rst_i = 1'b0;
        t_power_up();
        t_ctl_flag();
        t_freeze();
        t_input();
        t_output();
        t_service();
        t_halt();
        conclude();
    end
endmodule
`default_nettype wire
